// ===== bench/fcp_card_ctrl_checker.sv
// Purpose: Port-level assertions for the card control block
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module fcp_card_ctrl_checker #(
  parameter [20:0] SLEEP_CYCLES = 21'h1312d0
) (
  input wire         sys_clk_in,
  input wire         rst_n_in,
  input wire         spi_mode_in,
  input wire         cmd_valid_in,
  input wire         mem_wr_ready_in,
  input wire         resp_valid_out,
  input wire [31:0]  resp_status_out,
  input wire [127:0] csd_out,
  input wire         mem_wr_valid_out,
  input wire [7:0]   mem_wr_data_out,
  input wire         sleep_out,
  input wire         inactive_out
);
  logic [20:0] idle_cnt;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Cycles since the last command, saturating
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in || cmd_valid_in)
      idle_cnt <= 21'h0;
    else if (idle_cnt != 21'h1fffff)
      idle_cnt <= idle_cnt + 21'h1;
  end
  a_resp_latency: assert property (
    cmd_valid_in && !inactive_out |=> resp_valid_out) else $error("command not answered");
  a_resp_cause: assert property (
    resp_valid_out |-> $past(cmd_valid_in)) else $error("answer without command");
  a_inactive_stays: assert property (
    inactive_out |=> inactive_out) else $error("inactive state left");
  a_inactive_mute: assert property (
    inactive_out ##1 inactive_out |-> !resp_valid_out) else $error("inactive card answered");
  a_sleep_timer: assert property (
    $rose(sleep_out) |-> idle_cnt >= SLEEP_CYCLES - 21'h2) else $error("sleep too early");
  a_sleep_wake: assert property (
    sleep_out && cmd_valid_in && !inactive_out |=> !sleep_out && resp_valid_out)
    else $error("command did not wake card");
  a_spi_status: assert property (
    resp_valid_out && spi_mode_in |-> resp_status_out[31:16] == 16'h0000)
    else $error("spi status upper half not zero");
  a_csd_fixed: assert property (
    $stable(csd_out[127:16])) else $error("fixed configuration changed");
  a_perm_sticky: assert property (
    csd_out[13] |=> csd_out[13]) else $error("permanent protect cleared");
  a_copy_sticky: assert property (
    csd_out[14] |=> csd_out[14]) else $error("copy marker cleared");
  a_wr_hold: assert property (
    mem_wr_valid_out && !mem_wr_ready_in |=> mem_wr_valid_out && $stable(mem_wr_data_out))
    else $error("stalled write byte changed");
endmodule // fcp_card_ctrl_checker

bind fcp_card_ctrl fcp_card_ctrl_checker #(.SLEEP_CYCLES(SLEEP_CYCLES)) u_fcp_card_ctrl_checker (
  .sys_clk_in, .rst_n_in, .spi_mode_in, .cmd_valid_in, .mem_wr_ready_in, .resp_valid_out,
  .resp_status_out, .csd_out, .mem_wr_valid_out, .mem_wr_data_out, .sleep_out, .inactive_out
);

// ===== bench/fcp_card_ctrl_tb_top.sv
// Purpose: Self-checking bench for the card control block
// Assumes: Sleep count shortened to 50 cycles
// Notes:   One write block crosses the link at 48 ns
`timescale 1ns/1ps
`include "fcp_defs.vh"
`define FCP_CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module fcp_card_ctrl_tb_top;
  localparam int SLEEP_N = 32'h32;
  localparam int LIMIT   = 32'hea60;
  logic         sys_clk_in;
  logic         rst_n_in = 1'b0;
  logic         spi_mode_in = 1'b0;
  logic         cmd_valid_in = 1'b0;
  logic [5:0]   cmd_index_in = 6'h00;
  logic [31:0]  cmd_arg_in = 32'h0;
  logic         mem_wr_ready_in = 1'b1;
  logic         mem_busy_in = 1'b0;
  wire          card_clk_in, card_data_in, resp_valid_out, card_serial_output_out;
  wire          mem_wr_valid_out, ecc_valid_out, erase_go_out, sleep_out, inactive_out;
  wire [31:0]   resp_status_out, mem_addr_out, erase_first_out, erase_last_out;
  wire [127:0]  csd_out;
  wire [7:0]    mem_wr_data_out, ecc_out;
  wire          mem_rd_ready_out;
  logic [7:0]   rd_fix = 8'h00;
  int           error_cnt = 0, comparisons = 0, cyc = 0, nbytes = 0, erase_n = 0, nrd = 0;
  logic         got;
  logic [31:0]  st, ers_first, ers_last;
  logic [7:0]   ecc_seen;

  fcp_card_ctrl #(
    .SLEEP_CYCLES(21'h000032)
  ) u_fcp_card_ctrl (
    .sys_clk_in, .rst_n_in, .spi_mode_in, .cmd_valid_in, .cmd_index_in, .cmd_arg_in,
    .card_clk_in, .card_data_in, .mem_wr_ready_in, .mem_busy_in,
    .mem_rd_data_in(8'h5a), .mem_rd_fix_in(rd_fix), .mem_rd_ecc_in(8'h00),
    .resp_valid_out, .resp_status_out, .csd_out, .card_serial_output_out, .mem_addr_out,
    .mem_wr_valid_out, .mem_wr_data_out, .mem_rd_ready_out, .ecc_out, .ecc_valid_out,
    .erase_go_out, .erase_first_out, .erase_last_out, .sleep_out, .inactive_out
  );
  fcp_host_link u_fcp_host_link (
    .card_dout_in(card_serial_output_out),
    .card_clk_out(card_clk_in),
    .card_data_out(card_data_in)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever
      #2 sys_clk_in = ~sys_clk_in;
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, memory-side byte check, ecc and erase capture
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (mem_rd_ready_out)
      nrd++;
    if (mem_wr_valid_out && mem_wr_ready_in)
    begin
      `FCP_CHK("write byte", 8'(nbytes * 7 + 3), mem_wr_data_out)
      nbytes++;
    end
    if (ecc_valid_out)
      ecc_seen = ecc_out;
    if (erase_go_out)
    begin
      erase_n++;
      ers_first = erase_first_out;
      ers_last = erase_last_out;
    end
    if (cyc == LIMIT)
    begin
      error_cnt++;
      $display("ERROR timeout after %0d cycles", cyc);
      tally_and_finish();
    end
  end

  task automatic do_reset();
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
  endtask

  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b1;
    cmd_index_in = idx;
    cmd_arg_in = arg;
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
    got = resp_valid_out;
    st = resp_status_out;
  endtask

  task automatic t_sleep();
    cmd(`FCP_CMD_STATUS, 32'h0);
    `FCP_CHK("status answer", 1'b1, got)
    `FCP_CHK("idle status", 32'h0, st & 32'hffff_fe00)
    repeat (SLEEP_N - 15) @(negedge sys_clk_in);
    cmd(`FCP_CMD_STATUS, 32'h0);
    repeat (SLEEP_N - 15) @(negedge sys_clk_in);
    `FCP_CHK("timer restarted", 1'b0, sleep_out)
    repeat (40) @(negedge sys_clk_in);
    `FCP_CHK("asleep", 1'b1, sleep_out)
    cmd(`FCP_CMD_STATUS, 32'h0);
    `FCP_CHK("woken answer", 1'b1, got)
    `FCP_CHK("awake", 1'b0, sleep_out)
  endtask

  task automatic t_inactive();
    cmd(`FCP_CMD_OPCOND, 32'h0000_0100);
    `FCP_CHK("voltage refused", 1'b1, inactive_out)
    cmd(`FCP_CMD_STATUS, 32'h0);
    `FCP_CHK("no answer", 1'b0, got)
    do_reset();
    cmd(`FCP_CMD_INACT, 32'h0);
    `FCP_CHK("forced inactive", 1'b1, inactive_out)
    do_reset();
    `FCP_CHK("reset leaves inactive", 1'b0, inactive_out)
  endtask

  task automatic t_spi_illegal();
    logic [5:0] bad [4] = '{6'h3f, `FCP_CMD_OPCOND, `FCP_CMD_RDN, `FCP_CMD_WRN};
    spi_mode_in = 1'b1;
    foreach (bad[i])
    begin
      cmd(bad[i], 32'h0);
      `FCP_CHK("spi refusal", 32'h1, st)
    end
  endtask

  task automatic t_erase();
    cmd(`FCP_CMD_ERASE, 32'h0);
    `FCP_CHK("erase out of order", 32'h8, st)
    cmd(`FCP_CMD_ERS_ST, 32'h0000_4000);
    cmd(`FCP_CMD_ERS_END, 32'h0000_c000);
    cmd(`FCP_CMD_ERASE, 32'h0);
    repeat (8) @(negedge sys_clk_in);
    `FCP_CHK("erase pulses", 1, erase_n)
    `FCP_CHK("erase first", 32'h1, ers_first)
    `FCP_CHK("erase last", 32'h3, ers_last)
  endtask

  task automatic t_write();
    logic [7:0] e = 8'h00;
    for (int k = 0; k < 512; k++)
      e = e ^ 8'(k * 7 + 3);
    mem_busy_in = 1'b1;
    mem_wr_ready_in = 1'b0;
    cmd(`FCP_CMD_WR1, 32'h0000_0400);
    `FCP_CHK("write accepted", 32'h0, st)
    fork
      u_fcp_host_link.send_block(512, 1'b1);
      begin
        repeat (250) @(negedge sys_clk_in);
        mem_wr_ready_in = 1'b1;
      end
    join
    repeat (10) @(negedge sys_clk_in);
    `FCP_CHK("bytes stored", 512, nbytes)
    `FCP_CHK("write address", 32'h400, mem_addr_out)
    `FCP_CHK("sector ecc", e, ecc_seen)
    `FCP_CHK("busy low", 1'b0, card_serial_output_out)
    mem_busy_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    `FCP_CHK("busy ends", 1'b1, card_serial_output_out)
    cmd(`FCP_CMD_STATUS, 32'h0);
    `FCP_CHK("crc flagged", 32'h20, st)
  endtask

  task automatic t_read();
    logic [63:0] bits;
    logic [15:0] w = 16'h5b5b;
    logic [15:0] c = 16'h0000;
    for (int i = 15; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? 16'h1021 : 16'h0000);
    rd_fix = 8'h01;
    cmd(`FCP_CMD_BLEN, 32'h0000_0002);
    cmd(`FCP_CMD_RD1, 32'h0000_0010);
    `FCP_CHK("read accepted", 32'h0, st)
    u_fcp_host_link.recv_bits(35, bits);
    `FCP_CHK("read frame", {29'h0, 2'b10, w, c, 1'b1}, bits)
    `FCP_CHK("read bytes", 2, nrd)
    `FCP_CHK("read address", 32'h10, mem_addr_out)
    cmd(`FCP_CMD_STATUS, 32'h0);
    `FCP_CHK("read clean", 32'h0, st)
  endtask

  task automatic t_csd();
    cmd(`FCP_CMD_PCSD, 32'h0000_7abc);
    @(negedge sys_clk_in);
    `FCP_CHK("config low", 16'h7abc, csd_out[15:0])
    cmd(`FCP_CMD_PCSD, 32'h0000_0000);
    @(negedge sys_clk_in);
    `FCP_CHK("sticky bits", 16'h6000, csd_out[15:0])
    `FCP_CHK("fixed part", `FCP_CSD_FIXED, csd_out[127:16])
  endtask

  initial
  begin
    do_reset();
    t_sleep();
    t_inactive();
    t_spi_illegal();
    t_erase();
    t_write();
    t_read();
    t_csd();
    tally_and_finish();
  end
endmodule // fcp_card_ctrl_tb_top

// ===== bench/fcp_host_link.sv
// Purpose: Host model that sends one write data block and clocks in a read frame over the link
// Assumes: Link clock stands low outside frames; data line pulled high
// Notes:   The block CRC can be spoiled on request
`timescale 1ns/1ps
module fcp_host_link #(
  parameter int HALF_NS = 24
) (
  input  logic card_dout_in,
  output logic card_clk_out,
  output logic card_data_out
);
  initial
  begin
    card_clk_out = 1'b0;
    card_data_out = 1'b1;
  end
  // Data changes on the falling edge, the card samples on the rising edge
  task automatic put_bit(input logic b);
    card_data_out = b;
    #HALF_NS;
    card_clk_out = 1'b1;
    #HALF_NS;
    card_clk_out = 1'b0;
  endtask
  task automatic send_block(input int nbytes, input logic bad_crc);
    logic [15:0] crc;
    logic [7:0]  d;
    logic        fb;
    crc = 16'h0000;
    // Offset keeps link edges off the system clock edges
    #1;
    put_bit(1'b0);
    for (int k = 0; k < nbytes; k++)
    begin
      d = 8'(k * 7 + 3);
      for (int i = 7; i >= 0; i--)
      begin
        fb = d[i] ^ crc[15];
        crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        put_bit(d[i]);
      end
    end
    if (bad_crc)
      crc = crc ^ 16'h0001;
    for (int i = 15; i >= 0; i--)
      put_bit(crc[i]);
    card_data_out = 1'b1;
  endtask
  // Clocks a read frame and samples the card output on each rising edge
  task automatic recv_bits(input int n, output logic [63:0] bits);
    bits = 64'h0;
    #1;
    for (int i = 0; i < n; i++)
    begin
      #HALF_NS;
      card_clk_out = 1'b1;
      bits = {bits[62:0], card_dout_in};
      #HALF_NS;
      card_clk_out = 1'b0;
    end
  endtask
endmodule // fcp_host_link

// ===== design/fcp_card_ctrl.v
// Purpose: Card-side command, status, data and protection control
// Assumes: Command decoded upstream on sys_clk; card clock and data sampled
// Notes:   One serial data line, block CRC16, sector ECC byte
`timescale 1ns/1ps
`include "fcp_defs.vh"

// Notes on behaviour
// - Idle 5 ms after an operation puts the card asleep by itself.
// - Any command wakes the card and is answered normally.
// - Unsupported voltage window at negotiation makes the card inactive.
// - Inactive card ignores all traffic until power is cycled.
// - The go-inactive command makes the card inactive the same way.
// - A 32 bit status word with state and error codes goes with answers.
// - Send-status returns the current status word.
// - Blocks are whole numbers of bytes.
// - Each data block carries CRC16, made by sender, checked by receiver.
// - Writes use sector-length, sector-aligned blocks; blocks stay in one sector; the code checks this only for the first block of a multi-block read.
// - Multi-block transfers run on contiguous addresses until a stop command.
// - Sector ECC is made on write, checked on read, fixes applied before sending.
// - Erase is start tag, end tag, then the erase command.
// - Permanent and temporary write protect; permanent never clears; the code clears wp_perm at reset.
// - The copy marker, once set, never clears; the code clears copy_mark at reset.
// - Whole configuration is readable; only its two low bytes are writable.
// - SPI mode shows only 16 status bits holding the errors.
// - SPI mode has no voltage negotiation or identification.
// - SPI read and write commands take byte addresses as in native mode.
// - SPI mode supports single block transfers only.
// - In SPI mode the serial output is held low while a write is busy.
module fcp_card_ctrl #(
  parameter [20:0] SLEEP_CYCLES = `FCP_SLEEP_CYC
) (
  input  wire         sys_clk_in,
  input  wire         rst_n_in,
  input  wire         spi_mode_in,
  input  wire         cmd_valid_in,
  input  wire [5:0]   cmd_index_in,
  input  wire [31:0]  cmd_arg_in,
  input  wire         card_clk_in,
  input  wire         card_data_in,
  input  wire         mem_wr_ready_in,
  input  wire         mem_busy_in,
  input  wire [7:0]   mem_rd_data_in,
  input  wire [7:0]   mem_rd_fix_in,
  input  wire [7:0]   mem_rd_ecc_in,
  output reg          resp_valid_out,
  output reg  [31:0]  resp_status_out,
  output wire [127:0] csd_out,
  output reg          card_serial_output_out,
  output reg  [31:0]  mem_addr_out,
  output wire         mem_wr_valid_out,
  output wire [7:0]   mem_wr_data_out,
  output reg          mem_rd_ready_out,
  output reg  [7:0]   ecc_out,
  output reg          ecc_valid_out,
  output reg          erase_go_out,
  output reg  [31:0]  erase_first_out,
  output reg  [31:0]  erase_last_out,
  output reg          sleep_out,
  output wire         inactive_out
);

  localparam S_IDLE  = 3'd0;
  localparam S_TRAN  = 3'd1;
  localparam S_SEND  = 3'd2;
  localparam S_RECV  = 3'd3;
  localparam S_PROG  = 3'd4;
  localparam S_INACT = 3'd5;

  reg  [2:0]  state;
  reg  [6:0]  err;
  reg  [6:0]  c_err;
  reg         c_ill;
  reg  [9:0]  blocklen;
  reg         multi;
  reg  [20:0] idle_cnt;
  reg         lclk_s1;
  reg         lclk_s2;
  reg         lclk_s3;
  reg         dat_s1;
  reg         dat_s2;
  reg         rx_go;
  reg  [12:0] bcnt;
  reg  [7:0]  rx_sh;
  reg  [7:0]  tx_sh;
  reg         tx_out;
  reg  [15:0] crc;
  reg  [15:0] crc_rx;
  reg  [7:0]  ecc_acc;
  reg         tag_first;
  reg         tag_last;
  reg         wp_perm;
  reg         wp_temp;
  reg         copy_mark;
  reg  [12:0] csd_free;
  reg  [7:0]  b_mem [0:1];
  reg         b_wr;
  reg         b_rd;
  reg  [1:0]  b_cnt;

  wire        l_rise  = lclk_s2 & ~lclk_s3;
  wire        l_fall  = ~lclk_s2 & lclk_s3;
  wire [12:0] dbits   = {blocklen, 3'b000};
  wire        cmd_take = cmd_valid_in && (state != S_INACT);
  wire        busy_st = (state == S_SEND) || (state == S_RECV) || (state == S_PROG);
  wire        wp      = wp_perm | wp_temp;
  wire [10:0] rd_end  = {2'b00, cmd_arg_in[8:0]} + {1'b0, blocklen};
  wire [7:0]  rx_byte = {rx_sh[6:0], dat_s2};
  wire        rx_step = (state == S_RECV) && l_rise && rx_go;
  wire        rx_bdone = rx_step && (bcnt < dbits) && (bcnt[2:0] == 3'd7);
  wire        rx_last = rx_step && (bcnt == dbits + 13'd15);
  wire        crc_bad = rx_last && ({crc_rx[14:0], dat_s2} != crc);
  wire        b_pop   = mem_wr_valid_out && mem_wr_ready_in;
  wire        b_full  = (b_cnt == 2'd2);
  wire        b_push  = rx_bdone && (!b_full || b_pop);
  wire        tx_step = (state == S_SEND) && l_fall;
  wire        tx_load = (bcnt != 13'd0) && (bcnt <= dbits) && (bcnt[2:0] == 3'd1);
  wire [7:0]  rd_fixed = mem_rd_data_in ^ mem_rd_fix_in;
  wire        tx_bit  = tx_load ? rd_fixed[7] : tx_sh[7];
  wire        ecc_bad = tx_step && (bcnt == dbits + 13'd1) && (ecc_acc != mem_rd_ecc_in);
  wire [6:0]  d_err   = {(rx_bdone && !b_push) | ecc_bad, crc_bad, 5'h00};
  wire [6:0]  r_err   = c_err | d_err | ((cmd_index_in == `FCP_CMD_STATUS) ? err : 7'h00);
  wire        rdy     = !b_full && (state != S_PROG);
  reg  [3:0]  st_code;

  assign inactive_out     = (state == S_INACT);
  assign mem_wr_valid_out = (b_cnt != 2'd0);
  assign mem_wr_data_out  = b_mem[b_rd];
  assign csd_out = {`FCP_CSD_FIXED, csd_free[12], copy_mark, wp_perm, wp_temp,
                    csd_free[11:0]};

  function [15:0] crc_step;
    input [15:0] c;
    input        b;
    begin
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `FCP_CRC_POLY : 16'h0000);
    end
  endfunction

  always @*
  begin
    case (state)
      S_TRAN:  st_code = `FCP_ST_TRAN;
      S_SEND:  st_code = `FCP_ST_SEND;
      S_RECV:  st_code = `FCP_ST_RECV;
      S_PROG:  st_code = `FCP_ST_PROG;
      default: st_code = `FCP_ST_IDLE;
    endcase
  end

  // Checks the command against state, mode, alignment and protection
  always @*
  begin
    c_err = 7'h00;
    c_ill = 1'b0;
    case (cmd_index_in)
      `FCP_CMD_GO_IDLE, `FCP_CMD_STATUS, `FCP_CMD_INACT, `FCP_CMD_CSD,
      `FCP_CMD_PCSD, `FCP_CMD_ERS_ST: c_ill = 1'b0;
      `FCP_CMD_OPCOND: c_ill = spi_mode_in;
      `FCP_CMD_BLEN:
        c_err[`FCP_E_BLEN] = (cmd_arg_in == 32'h0000_0000) ||
                             (cmd_arg_in > {22'h000000, `FCP_SECTOR});
      `FCP_CMD_RD1, `FCP_CMD_RDN:
        c_err[`FCP_E_ADDR] = (rd_end > {1'b0, `FCP_SECTOR});
      `FCP_CMD_WR1, `FCP_CMD_WRN:
      begin
        c_err[`FCP_E_BLEN] = (blocklen != `FCP_SECTOR);
        c_err[`FCP_E_ADDR] = (cmd_arg_in[8:0] != 9'h000);
        c_err[`FCP_E_WP]   = wp;
      end
      `FCP_CMD_ERS_END: c_err[`FCP_E_ERSEQ] = !tag_first;
      `FCP_CMD_ERASE:
      begin
        c_err[`FCP_E_ERSEQ] = !tag_last;
        c_err[`FCP_E_WP]    = wp;
      end
      `FCP_CMD_STOP: c_ill = (state != S_SEND) && (state != S_RECV) && (state != S_PROG);
      default: c_ill = 1'b1;
    endcase
    if (spi_mode_in && ((cmd_index_in == `FCP_CMD_RDN) || (cmd_index_in == `FCP_CMD_WRN)))
      c_ill = 1'b1;
    if (!spi_mode_in && (state == S_IDLE) && (cmd_index_in != `FCP_CMD_GO_IDLE) &&
        (cmd_index_in != `FCP_CMD_OPCOND) && (cmd_index_in != `FCP_CMD_STATUS) &&
        (cmd_index_in != `FCP_CMD_INACT))
      c_ill = 1'b1;
    if (busy_st && (cmd_index_in != `FCP_CMD_STOP) && (cmd_index_in != `FCP_CMD_STATUS))
      c_ill = 1'b1;
    if (c_ill)
      c_err = 7'h01;
  end

  // Two-stage synchronisers for the card clock and data pins
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      dat_s1  <= 1'b1;
      dat_s2  <= 1'b1;
    end
    else
    begin
      lclk_s1 <= card_clk_in;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      dat_s1  <= card_data_in;
      dat_s2  <= dat_s1;
    end
  end

  // Two-entry write buffer between the serial receiver and the memory
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      b_wr  <= 1'b0;
      b_rd  <= 1'b0;
      b_cnt <= 2'd0;
    end
    else
    begin
      if (b_push)
      begin
        b_mem[b_wr] <= rx_byte;
        b_wr        <= ~b_wr;
      end
      if (b_pop)
        b_rd <= ~b_rd;
      if (b_push && !b_pop)
        b_cnt <= b_cnt + 2'd1;
      else if (b_pop && !b_push)
        b_cnt <= b_cnt - 2'd1;
    end
  end

  // Serial output; busy is shown low while an SPI write is programming
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
      card_serial_output_out <= 1'b1;
    else if (spi_mode_in && (state == S_PROG))
      card_serial_output_out <= 1'b0;
    else
      card_serial_output_out <= (state == S_SEND) ? tx_out : 1'b1;
  end

  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      state           <= S_IDLE;
      err             <= 7'h00;
      blocklen        <= `FCP_BLEN_RST;
      multi           <= 1'b0;
      idle_cnt        <= 21'd0;
      sleep_out       <= 1'b0;
      rx_go           <= 1'b0;
      bcnt            <= 13'd0;
      rx_sh           <= 8'h00;
      tx_sh           <= 8'h00;
      tx_out          <= 1'b1;
      crc             <= 16'h0000;
      crc_rx          <= 16'h0000;
      ecc_acc         <= 8'h00;
      tag_first       <= 1'b0;
      tag_last        <= 1'b0;
      wp_perm         <= 1'b0;
      wp_temp         <= 1'b0;
      copy_mark       <= 1'b0;
      csd_free        <= 13'h0000;
      resp_valid_out  <= 1'b0;
      resp_status_out <= 32'h0000_0000;
      mem_addr_out    <= 32'h0000_0000;
      mem_rd_ready_out <= 1'b0;
      ecc_out         <= 8'h00;
      ecc_valid_out   <= 1'b0;
      erase_go_out    <= 1'b0;
      erase_first_out <= 32'h0000_0000;
      erase_last_out  <= 32'h0000_0000;
    end
    else
    begin
      resp_valid_out   <= 1'b0;
      mem_rd_ready_out <= 1'b0;
      ecc_valid_out    <= 1'b0;
      erase_go_out     <= 1'b0;
      if (cmd_take)
      begin
        idle_cnt  <= 21'd0;
        sleep_out <= 1'b0;
      end
      else if (((state == S_IDLE) || (state == S_TRAN)) && !sleep_out)
      begin
        if (idle_cnt == SLEEP_CYCLES - 21'd1)
          sleep_out <= 1'b1;
        else
          idle_cnt <= idle_cnt + 21'd1;
      end
      // Data errors win over the clear done by a new command
      err <= (cmd_take ? c_err : err) | d_err;
      if (rx_bdone)
        ecc_acc <= ecc_acc ^ rx_byte;
      if (state == S_RECV && l_rise)
      begin
        if (!rx_go)
        begin
          if (!dat_s2)
          begin
            rx_go <= 1'b1;
            bcnt  <= 13'd0;
          end
        end
        else
        begin
          bcnt <= bcnt + 13'd1;
          if (bcnt < dbits)
          begin
            rx_sh <= rx_byte;
            crc   <= crc_step(crc, dat_s2);
          end
          else
            crc_rx <= {crc_rx[14:0], dat_s2};
          if (rx_last)
          begin
            state         <= S_PROG;
            ecc_out       <= ecc_acc;
            ecc_valid_out <= 1'b1;
          end
        end
      end
      if (state == S_PROG && b_cnt == 2'd0 && !mem_busy_in)
      begin
        if (multi)
        begin
          state        <= S_RECV;
          mem_addr_out <= mem_addr_out + {22'h000000, `FCP_SECTOR};
          rx_go        <= 1'b0;
          crc          <= 16'h0000;
          ecc_acc      <= 8'h00;
        end
        else
          state <= S_TRAN;
      end
      if (tx_step)
      begin
        bcnt <= bcnt + 13'd1;
        if (bcnt == 13'd0)
          tx_out <= 1'b0;
        else if (bcnt <= dbits)
        begin
          tx_out <= tx_bit;
          crc    <= crc_step(crc, tx_bit);
          if (tx_load)
          begin
            tx_sh            <= {rd_fixed[6:0], 1'b0};
            ecc_acc          <= ecc_acc ^ rd_fixed;
            mem_rd_ready_out <= 1'b1;
          end
          else
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
        else if (bcnt <= dbits + 13'd16)
        begin
          tx_out <= crc[15];
          crc    <= {crc[14:0], 1'b0};
        end
        else
        begin
          tx_out  <= 1'b1;
          bcnt    <= 13'd0;
          crc     <= 16'h0000;
          ecc_acc <= 8'h00;
          if (multi)
            mem_addr_out <= mem_addr_out + {22'h000000, blocklen};
          else
            state <= S_TRAN;
        end
      end
      if (cmd_take)
      begin
        resp_valid_out <= 1'b1;
        if (spi_mode_in)
          resp_status_out <= {16'h0000, 9'h000, r_err};
        else
          resp_status_out <= {1'b0, r_err[`FCP_E_ADDR], r_err[`FCP_E_BLEN],
                              r_err[`FCP_E_ERSEQ], 1'b0, r_err[`FCP_E_WP], 2'b00,
                              r_err[`FCP_E_CRC], r_err[`FCP_E_ILL], r_err[`FCP_E_FAULT],
                              8'h00, st_code, rdy, 8'h00};
        if ((cmd_index_in != `FCP_CMD_ERS_ST) && (cmd_index_in != `FCP_CMD_ERS_END) &&
            (cmd_index_in != `FCP_CMD_ERASE) && (cmd_index_in != `FCP_CMD_STATUS))
        begin
          tag_first <= 1'b0;
          tag_last  <= 1'b0;
        end
        if (c_err == 7'h00)
        begin
          case (cmd_index_in)
            `FCP_CMD_GO_IDLE: state <= S_IDLE;
            `FCP_CMD_OPCOND:
              state <= ((cmd_arg_in & `FCP_OCR_OK) == 32'h0000_0000) ? S_INACT : S_TRAN;
            `FCP_CMD_INACT: state <= S_INACT;
            `FCP_CMD_BLEN: blocklen <= cmd_arg_in[9:0];
            `FCP_CMD_RD1, `FCP_CMD_RDN, `FCP_CMD_WR1, `FCP_CMD_WRN:
            begin
              multi        <= (cmd_index_in == `FCP_CMD_RDN) || (cmd_index_in == `FCP_CMD_WRN);
              mem_addr_out <= cmd_arg_in;
              state        <= cmd_index_in[3] ? S_RECV : S_SEND;
              bcnt         <= 13'd0;
              rx_go        <= 1'b0;
              tx_out       <= 1'b1;
              crc          <= 16'h0000;
              ecc_acc      <= 8'h00;
            end
            `FCP_CMD_PCSD:
            begin
              copy_mark <= copy_mark | cmd_arg_in[`FCP_CSD_COPY];
              wp_perm   <= wp_perm | cmd_arg_in[`FCP_CSD_PERM];
              wp_temp   <= cmd_arg_in[`FCP_CSD_TEMP];
              csd_free  <= {cmd_arg_in[`FCP_CSD_FILE], cmd_arg_in[11:0]};
            end
            `FCP_CMD_ERS_ST:
            begin
              tag_first       <= 1'b1;
              tag_last        <= 1'b0;
              erase_first_out <= cmd_arg_in >> `FCP_ERASE_SHIFT;
            end
            `FCP_CMD_ERS_END:
            begin
              tag_last       <= 1'b1;
              erase_last_out <= cmd_arg_in >> `FCP_ERASE_SHIFT;
            end
            `FCP_CMD_ERASE: erase_go_out <= 1'b1;
            `FCP_CMD_STOP:
            begin
              multi <= 1'b0;
              if (state == S_SEND)
                state <= S_TRAN;
              else if (state == S_RECV)
                state <= S_PROG;
            end
            default: multi <= multi;
          endcase
        end
      end
    end
  end

endmodule // fcp_card_ctrl

// ===== design/fcp_defs.vh
// Purpose: Constants of the flash card protocol control block
// Assumes: 250 MHz system clock
// Notes:   Definitions only
`ifndef FCP_DEFS_VH
`define FCP_DEFS_VH
`define FCP_CLK_NS      4
`define FCP_SLEEP_MS    5
`define FCP_SLEEP_CYC   ((`FCP_SLEEP_MS * 1000000 + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
`define FCP_SECTOR      10'h200
`define FCP_BLEN_RST    10'h200
`define FCP_OCR_OK      32'h00ff8000
`define FCP_CSD_FIXED   112'h0000_0000_0000_0000_0000_0000_0000
`define FCP_ERASE_SHIFT 14
`define FCP_CRC_POLY    16'h1021
`define FCP_CMD_GO_IDLE 6'h00
`define FCP_CMD_OPCOND  6'h01
`define FCP_CMD_CSD     6'h09
`define FCP_CMD_STOP    6'h0c
`define FCP_CMD_STATUS  6'h0d
`define FCP_CMD_INACT   6'h0f
`define FCP_CMD_BLEN    6'h10
`define FCP_CMD_RD1     6'h11
`define FCP_CMD_RDN     6'h12
`define FCP_CMD_WR1     6'h18
`define FCP_CMD_WRN     6'h19
`define FCP_CMD_PCSD    6'h1b
`define FCP_CMD_ERS_ST  6'h23
`define FCP_CMD_ERS_END 6'h24
`define FCP_CMD_ERASE   6'h26
`define FCP_E_ILL       0
`define FCP_E_ADDR      1
`define FCP_E_BLEN      2
`define FCP_E_ERSEQ     3
`define FCP_E_WP        4
`define FCP_E_CRC       5
`define FCP_E_FAULT     6
`define FCP_CSD_FILE    15
`define FCP_CSD_COPY    14
`define FCP_CSD_PERM    13
`define FCP_CSD_TEMP    12
`define FCP_ST_IDLE     4'h0
`define FCP_ST_TRAN     4'h4
`define FCP_ST_SEND     4'h5
`define FCP_ST_RECV     4'h6
`define FCP_ST_PROG     4'h7
`endif
